// ===== hw/reference_clock_demodulator.sv
// Four-channel reference clock demodulator with register port
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module reference_clock_demodulator
   import ref_demod_pkg::*;
#(
   parameter int CNT_W = 10,
   parameter int PER_W = 16
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] carrierIn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   output logic [3:0] syncPulse,
   output logic [3:0] refDividerReset,
   output logic [3:0] tdcTag,
   output logic [3:0] polarityOut
);

   //-----------------------------------------------------------------
   // Declarations
   //-----------------------------------------------------------------
   logic [7:0] cfg_reg [4];
   logic [7:0] band_reg [2];
   logic [1:0] diff_reg;
   logic [3:0] s1_reg, s2_reg, s3_reg, carLvl_reg, primed_reg, blank_reg;
   logic [CNT_W-1:0] hiCnt_reg [4];
   logic [CNT_W-1:0] perCnt_reg [4];
   logic [PER_W-1:0] evtCnt_reg [4];
   logic [PER_W-1:0] learned_reg [4];
   logic [2:0] streak_reg [4];
   logic [2:0] wait_reg [4];
   logic [3:0] rise, active, realEvt, virtEvt, evt, fire, locked;
   duty_t cls [4];

   // Sort one carrier period by duty cycle against a sensitivity margin
   function automatic duty_t classify(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] per,
                                      input logic [1:0] sens, input logic band);
      logic [CNT_W+1:0] twiceHi;
      logic [CNT_W+1:0] thr;
      logic [CNT_W+1:0] perW;
      logic [2:0] sh;
      twiceHi = {1'b0, hi, 1'b0};
      perW = {2'b00, per};
      sh = THR_BASE_SHIFT - {1'b0, sens} - {2'b00, band};
      thr = perW >> sh;
      if (twiceHi + thr < perW) begin
         classify = CLS_SHORT;
      end else if (twiceHi > perW + thr) begin
         classify = CLS_LONG;
      end else begin
         classify = CLS_NOM;
      end
   endfunction

   //-----------------------------------------------------------------
   // Register port
   //-----------------------------------------------------------------
   // Configuration writes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            cfg_reg[i] <= CFG_RST;
         end
         band_reg[0] <= BAND_RST;
         band_reg[1] <= BAND_RST;
         diff_reg <= DIFF_RST;
      end else if (regWr) begin
         unique case (regAddr)
            BAND_A_OFS: band_reg[0] <= regWdata;
            BAND_B_OFS: band_reg[1] <= regWdata;
            CFG_A_OFS: cfg_reg[0] <= regWdata;
            CFG_AA_OFS: cfg_reg[1] <= regWdata;
            CFG_B_OFS: cfg_reg[2] <= regWdata;
            CFG_BB_OFS: cfg_reg[3] <= regWdata;
            DIFF_OFS: diff_reg <= regWdata[1:0];
            default: ;
         endcase
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            BAND_A_OFS: regRdata <= band_reg[0];
            BAND_B_OFS: regRdata <= band_reg[1];
            CFG_A_OFS: regRdata <= cfg_reg[0];
            CFG_AA_OFS: regRdata <= cfg_reg[1];
            CFG_B_OFS: regRdata <= cfg_reg[2];
            CFG_BB_OFS: regRdata <= cfg_reg[3];
            DIFF_OFS: regRdata <= {6'h00, diff_reg};
            STAT_OFS: regRdata <= {polarityOut, locked};
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   //-----------------------------------------------------------------
   // Carrier capture
   //-----------------------------------------------------------------
   // Three-stage synchroniser, level accepted when stages two and three agree
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
         carLvl_reg <= 4'h0;
      end else begin
         s1_reg <= carrierIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < 4; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               carLvl_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   // Per-channel decode of the current carrier period
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         rise[i] = s2_reg[i] & s3_reg[i] & ~carLvl_reg[i];
         active[i] = cfg_reg[i][EN_BIT] & ~((i % 2 == 1) & diff_reg[i/2]);
         cls[i] = classify(hiCnt_reg[i], perCnt_reg[i], cfg_reg[i][SENS_LSB+:2], band_reg[i/2][BAND_BIT]);
         realEvt[i] = 1'b0;
         if (rise[i] && active[i] && primed_reg[i] && !blank_reg[i]) begin
            if (cfg_reg[i][AUTO_BIT]) begin
               realEvt[i] = (cls[i] != CLS_NOM);
            end else begin
               realEvt[i] = (cls[i] == (cfg_reg[i][POL_BIT] ? CLS_LONG : CLS_SHORT));
            end
         end
         locked[i] = (streak_reg[i] >= PERSIST_EVENTS);
         virtEvt[i] = rise[i] & active[i] & ~realEvt[i] & locked[i] & cfg_reg[i][PERSIST_BIT]
                      & (evtCnt_reg[i] + 1'b1 == learned_reg[i]);
         evt[i] = realEvt[i] | virtEvt[i];
         fire[i] = rise[i] & (wait_reg[i] == 3'h1);
      end
   end

   // Pulse width and period measured in system clocks
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            hiCnt_reg[i] <= '0;
            perCnt_reg[i] <= '0;
         end
         primed_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (rise[i]) begin
               hiCnt_reg[i] <= '0;
               // Rise cycle counted so a full period reads its own length
               perCnt_reg[i] <= {{(CNT_W-1){1'b0}}, 1'b1};
               primed_reg[i] <= active[i];
            end else begin
               // Disabled channel ignores its first period again
               if (!active[i]) begin
                  primed_reg[i] <= 1'b0;
               end
               if (perCnt_reg[i] != '1) begin
                  perCnt_reg[i] <= perCnt_reg[i] + 1'b1;
               end
               if (carLvl_reg[i] && hiCnt_reg[i] != '1) begin
                  hiCnt_reg[i] <= hiCnt_reg[i] + 1'b1;
               end
            end
         end
      end
   end

   //-----------------------------------------------------------------
   // Event handling
   //-----------------------------------------------------------------
   // Blank the second period of every real event and latch polarity
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         blank_reg <= 4'h0;
         polarityOut <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (rise[i]) begin
               blank_reg[i] <= realEvt[i];
            end
            if (!cfg_reg[i][AUTO_BIT] || !active[i]) begin
               polarityOut[i] <= 1'b0;
            end else if (realEvt[i]) begin
               polarityOut[i] <= (cls[i] == CLS_LONG);
            end
         end
      end
   end

   // Learn modulation period and count matching events
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            evtCnt_reg[i] <= '0;
            learned_reg[i] <= '0;
            streak_reg[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!active[i]) begin
               evtCnt_reg[i] <= '0;
               streak_reg[i] <= 3'h0;
            end else if (evt[i]) begin
               evtCnt_reg[i] <= '0;
               learned_reg[i] <= evtCnt_reg[i] + 1'b1;
               if (evtCnt_reg[i] + 1'b1 != learned_reg[i]) begin
                  streak_reg[i] <= 3'h1;
               end else if (!locked[i]) begin
                  streak_reg[i] <= streak_reg[i] + 1'b1;
               end
            end else if (rise[i]) begin
               if (evtCnt_reg[i] == '1) begin
                  streak_reg[i] <= 3'h0;
               end else begin
                  evtCnt_reg[i] <= evtCnt_reg[i] + 1'b1;
               end
            end
         end
      end
   end

   // Sync-edge countdown from base edge, one step per carrier rise
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            wait_reg[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!active[i]) begin
               wait_reg[i] <= 3'h0;
            end else if (evt[i]) begin
               wait_reg[i] <= {1'b0, cfg_reg[i][EDGE_LSB+:2]} + 3'h1;
            end else if (rise[i] && wait_reg[i] != 3'h0) begin
               wait_reg[i] <= wait_reg[i] - 3'h1;
            end
         end
      end
   end

   // Output pulse held from one carrier rise to the next
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         syncPulse <= 4'h0;
         refDividerReset <= 4'h0;
         tdcTag <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!active[i]) begin
               syncPulse[i] <= 1'b0;
               refDividerReset[i] <= 1'b0;
               tdcTag[i] <= 1'b0;
            end else if (rise[i]) begin
               syncPulse[i] <= fire[i];
               refDividerReset[i] <= fire[i];
               tdcTag[i] <= fire[i];
            end
         end
      end
   end

   //-----------------------------------------------------------------
   // Assertions
   //-----------------------------------------------------------------
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   pulse_one_period_a: assert property (syncPulse[0] && rise[0] && !fire[0] |=> !syncPulse[0])
      else $error("pulse outlived one carrier period");
   pulse_start_a: assert property ($rose(syncPulse[0]) |-> $past(rise[0] && wait_reg[0] == 3'h1))
      else $error("pulse started off the sync edge");
   edge_load_a: assert property (evt[0] |=> wait_reg[0] == $past({1'b0, cfg_reg[0][5:4]}) + 3'h1)
      else $error("sync edge count not loaded");
   manual_pol_a: assert property (rise[0] && active[0] && primed_reg[0] && !blank_reg[0]
      && !cfg_reg[0][7] && !cfg_reg[0][2] && cls[0] == CLS_SHORT |-> realEvt[0])
      else $error("normal event missed");
   no_pol_out_a: assert property (!cfg_reg[0][7] |=> !polarityOut[0])
      else $error("polarity out without auto detect");
   pol_latch_a: assert property (realEvt[0] && cfg_reg[0][7] && active[0]
      |=> polarityOut[0] == $past(cls[0] == CLS_LONG))
      else $error("polarity not latched");
   persist_gate_a: assert property (virtEvt[0] |-> cfg_reg[0][6] && streak_reg[0] >= 3'h5)
      else $error("persistent pulse before five events");
   disabled_quiet_a: assert property (!cfg_reg[0][3] |=> !syncPulse[0] ##1 !syncPulse[0])
      else $error("disabled channel pulsed");
   diff_pair_a: assert property (diff_reg[0] |=> !syncPulse[1])
      else $error("second demodulator of pair active");
   tag_follow_a: assert property (tdcTag == syncPulse && refDividerReset == syncPulse)
      else $error("divider reset or tag diverged");
   sens_thr_a: assert property (cfg_reg[0][1:0] == 2'h3 && perCnt_reg[0] == 10'h020
      && hiCnt_reg[0] == 10'h00C |-> cls[0] == CLS_NOM)
      else $error("least sensitive setting detected small change");

   event_c: cover property (realEvt[0] ##[1:200] $rose(syncPulse[0]));
   persist_c: cover property (virtEvt[0] ##[1:200] $rose(syncPulse[0]));
   auto_alt_c: cover property (realEvt[0] && cfg_reg[0][7] ##1 polarityOut[0]);
endmodule // reference_clock_demodulator

// ===== hw/ref_demod_pkg.sv
// Constants, field layout and types of the reference clock demodulator
//-----------------------------------------------------------------
// Operation
// - Output pulse lasts one carrier period
// - Next carrier rise after event is base edge
// - Sync-edge field D5:D4 places pulse after base
// - Event spans two periods, short-long or long-short
// - Bit D2 gives expected polarity when auto off
// - Bit D7 enables automatic polarity detection
// - Auto detection latches polarity, else none
// - Field D1:D0 sets sensitivity, zero most sensitive
// - Persistence learns period, keeps pulsing afterwards
// - Bit D6 enables persistence
// - Persistent output needs five consecutive events
// - Band bit D0 selects carrier range
// - One band bit serves each reference pair
// - Four config registers at 0x302, 0x303, 0x306 and 0x307
// - Bit D3 enables the demodulator
// - Pulse resets divider and tags converter
// - Differential input uses one pair demodulator
//-----------------------------------------------------------------
package ref_demod_pkg;
   // Register offsets
   localparam logic [15:0] BAND_A_OFS = 16'h0301;
   localparam logic [15:0] CFG_A_OFS = 16'h0302;
   localparam logic [15:0] CFG_AA_OFS = 16'h0303;
   localparam logic [15:0] BAND_B_OFS = 16'h0305;
   localparam logic [15:0] CFG_B_OFS = 16'h0306;
   localparam logic [15:0] CFG_BB_OFS = 16'h0307;
   localparam logic [15:0] DIFF_OFS = 16'h0308;
   localparam logic [15:0] STAT_OFS = 16'h0309;
   // Field positions
   localparam int SENS_LSB = 0;
   localparam int POL_BIT = 2;
   localparam int EN_BIT = 3;
   localparam int EDGE_LSB = 4;
   localparam int PERSIST_BIT = 6;
   localparam int AUTO_BIT = 7;
   localparam int BAND_BIT = 0;
   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] BAND_RST = 8'h00;
   localparam logic [1:0] DIFF_RST = 2'h0;
   // Counts
   localparam logic [2:0] PERSIST_EVENTS = 3'h5;
   localparam logic [2:0] THR_BASE_SHIFT = 3'h5;
   // Duty class of one carrier period
   typedef enum logic [1:0] {
      CLS_NOM = 2'b00,
      CLS_SHORT = 2'b01,
      CLS_LONG = 2'b10
   } duty_t;
endpackage

// ===== bench/carrier_source.sv
// Modulated carrier model standing in for the remote timing device
`timescale 1ns/1ps
module carrier_source #(
   parameter int HALF_NS = 64
) (
   input wire logic run,
   input wire logic alt,
   input wire logic [15:0] depth,
   input wire logic [15:0] spacing,
   input wire logic [15:0] events,
   output logic carrier,
   output logic [15:0] sinceEvent,
   output logic [15:0] sent
);
   logic [15:0] cnt;
   logic evt;
   logic prevEvt;
   int hi;

   // One carrier period per pass; held low between frames
   initial begin
      carrier = 1'b0;
      sinceEvent = 16'h0;
      prevEvt = 1'b0;
      {cnt, sent, evt} = '0;
      #1;
      forever begin
         if (!run) begin
            carrier = 1'b0;
            {cnt, sent, evt} = {16'h2, 16'h0, 1'b0};
            #4;
         end else begin
            carrier = 1'b1;
            // Rises counted from the end of the last event period
            sinceEvent = evt ? 16'h0 : sinceEvent + 16'h1;
            prevEvt = evt;
            evt = (cnt == 16'h0) && (sent < events);
            sent = sent + {15'h0, evt};
            hi = HALF_NS;
            if (evt) begin
               hi = alt ? HALF_NS + int'(depth) : HALF_NS - int'(depth);
            end
            if (prevEvt) begin
               hi = alt ? HALF_NS - int'(depth) : HALF_NS + int'(depth);
            end
            #(hi);
            carrier = 1'b0;
            #(2 * HALF_NS - hi);
            cnt = (cnt + 16'h1 == spacing) ? 16'h0 : cnt + 16'h1;
         end
      end
   end
endmodule // carrier_source

// ===== bench/reference_clock_demodulator_tb_top.sv
// Self-checking bench for the reference clock demodulator
`timescale 1ns/1ps
module reference_clock_demodulator_tb_top
   import ref_demod_pkg::*;
;
   localparam int PER = 32;
   logic mclk;
   logic reset_n;
   logic [15:0] regAddr;
   logic [7:0] regWdata;
   logic regWr;
   logic regRd;
   logic [7:0] regRdata;
   logic [3:0] syncPulse;
   logic [3:0] refDividerReset;
   logic [3:0] tdcTag;
   logic [3:0] polarityOut;
   logic run;
   logic alt;
   logic [15:0] depth;
   logic [15:0] events;
   logic carrier;
   logic [15:0] sinceEvent;
   logic [15:0] sent;
   logic [15:0] cfgAddr [4] = '{CFG_A_OFS, CFG_AA_OFS, CFG_B_OFS, CFG_BB_OFS};
   int failures;
   int check_count;

   reference_clock_demodulator reference_clock_demodulator_inst (
      .mclk(mclk), .reset_n(reset_n), .carrierIn({4{carrier}}), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .syncPulse(syncPulse), .refDividerReset(refDividerReset), .tdcTag(tdcTag),
      .polarityOut(polarityOut));

   carrier_source carrier_source_inst (
      .run(run), .alt(alt), .depth(depth), .spacing(16'hA), .events(events),
      .carrier(carrier), .sinceEvent(sinceEvent), .sent(sent));

   // Clock at 4 ns period
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic regCheck(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      check("regRdata", {8'h0, exp}, {8'h0, regRdata});
   endtask

   //--------------------------------------------------------------
   // Scenarios
   //--------------------------------------------------------------
   task automatic test_registers();
      logic [15:0] map [6] = '{BAND_A_OFS, CFG_A_OFS, CFG_AA_OFS, BAND_B_OFS, CFG_B_OFS, CFG_BB_OFS};
      logic [7:0] val [6] = '{8'h01, 8'hA5, 8'h5A, 8'h01, 8'hC3, 8'h3C};
      check("outputs", 16'h0, {syncPulse, refDividerReset, tdcTag, polarityOut});
      for (int i = 0; i < 6; i++) begin
         regCheck(map[i], 8'h00);
      end
      for (int i = 0; i < 6; i++) begin
         regWrite(map[i], val[i]);
      end
      regWrite(16'h0304, 8'hFF);
      regCheck(16'h0304, 8'h00);
      for (int i = 0; i < 6; i++) begin
         regCheck(map[i], val[i]);
         regWrite(map[i], 8'h00);
      end
   endtask

   // One event on a channel, then judge placement, width, copies, polarity
   task automatic burst(input int ch, input logic [7:0] cfg, input logic a, input logic [15:0] d,
         input logic [15:0] expRise, input logic expPol);
      int n;
      regWrite(cfgAddr[ch], 8'h00);
      regWrite(cfgAddr[ch], cfg);
      alt = a;
      depth = d;
      events = 16'h1;
      run = 1'b1;
      n = 0;
      while (syncPulse[ch] !== 1'b1 && n < 25 * PER) begin
         tick(1);
         n++;
      end
      check("pulse place", expRise, (syncPulse[ch] === 1'b1) ? sinceEvent : 16'h0);
      if (syncPulse[ch] !== 1'b1 && expRise != 16'h0) begin
         report_and_stop();
      end
      if (expRise != 16'h0) begin
         check("copies and polarity", 16'h6 | 16'(expPol), {13'h0, refDividerReset[ch], tdcTag[ch], polarityOut[ch]});
         n = 0;
         while (syncPulse[ch] === 1'b1 && n < 2 * PER) begin
            tick(1);
            n++;
         end
         check("pulse width", 16'(PER), 16'(n));
         if (n >= 2 * PER) begin
            report_and_stop();
         end
         check("copies low", 16'h0, {14'h0, refDividerReset[ch], tdcTag[ch]});
      end
      run = 1'b0;
      tick(3 * PER);
   endtask

   // Pulses that go on after the modulation stops
   task automatic persist(input logic [7:0] cfg, input logic [15:0] n, input int exp);
      int k;
      int seen;
      logic prev;
      regWrite(CFG_A_OFS, 8'h00);
      regWrite(CFG_A_OFS, cfg);
      alt = 1'b0;
      depth = 16'h20;
      events = n;
      run = 1'b1;
      k = 0;
      while (sent !== n && k < 200 * PER) begin
         tick(1);
         k++;
      end
      check("events sent", n, sent);
      if (sent !== n) begin
         report_and_stop();
      end
      tick(5 * PER);
      seen = 0;
      prev = 1'b0;
      for (int c = 0; c < 30 * PER; c++) begin
         tick(1);
         seen += int'(syncPulse[0] === 1'b1 && !prev);
         prev = syncPulse[0];
      end
      check("persist pulses", 16'(exp), 16'(seen));
      run = 1'b0;
      tick(4 * PER);
   endtask

   initial begin
      reset_n = 1'b0;
      {regAddr, regWdata, regWr, regRd} = '0;
      {run, alt, depth, events} = '0;
      failures = 0;
      check_count = 0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      tick(1);
      test_registers();
      for (int e = 1; e < 4; e++) begin
         burst(0, 8'h08 | 8'(e << EDGE_LSB), 1'b0, 16'h20, 16'(e + 1), 1'b0);
      end
      burst(1, 8'h10, 1'b0, 16'h20, 16'h0, 1'b0);
      regWrite(DIFF_OFS, 8'h01);
      regCheck(DIFF_OFS, 8'h01);
      burst(1, 8'h18, 1'b0, 16'h20, 16'h0, 1'b0);
      regWrite(DIFF_OFS, 8'h00);
      burst(0, 8'h18, 1'b1, 16'h20, 16'h3, 1'b0);
      burst(0, 8'h1C, 1'b1, 16'h20, 16'h2, 1'b0);
      burst(0, 8'h98, 1'b1, 16'h20, 16'h2, 1'b1);
      burst(0, 8'h9C, 1'b0, 16'h20, 16'h2, 1'b0);
      burst(0, 8'h18, 1'b0, 16'h10, 16'h2, 1'b0);
      burst(0, 8'h1B, 1'b0, 16'h10, 16'h0, 1'b0);
      regWrite(BAND_A_OFS, 8'h01);
      burst(0, 8'h1A, 1'b0, 16'h10, 16'h0, 1'b0);
      burst(2, 8'h1A, 1'b0, 16'h10, 16'h2, 1'b0);
      regWrite(BAND_A_OFS, 8'h00);
      burst(1, 8'h1A, 1'b0, 16'h10, 16'h2, 1'b0);
      regWrite(CFG_AA_OFS, 8'h00);
      regWrite(CFG_B_OFS, 8'h00);
      persist(8'h58, 16'h4, 0);
      persist(8'h18, 16'h8, 0);
      persist(8'h58, 16'h8, 3);
      regCheck(STAT_OFS, 8'h01);
      report_and_stop();
   end
endmodule // reference_clock_demodulator_tb_top
